// ---- rtl/asr_pkg.sv ----
package asr_pkg;

  // Register location and field positions
  localparam logic [4:0] STATUS_ADDR    = 5'h03;
  localparam int         BIT_RSV_PAGE   = 7;
  localparam int         BIT_PAGE_HI    = 6;
  localparam int         BIT_PAGE_LO    = 5;
  localparam int         BIT_TIMEOUT    = 4;
  localparam int         BIT_POWERDOWN  = 3;
  localparam int         BIT_ZERO       = 2;
  localparam int         BIT_DIGIT      = 1;
  localparam int         BIT_CARRY      = 0;
  localparam int         PAGE_WORDS_LOG = 9;

  // Reset values of the upper bits (arithmetic flags are not reset)
  localparam logic [2:0] PAGE_RESET     = 3'h0;
  localparam logic       TIMEOUT_POR    = 1'b1;
  localparam logic       POWERDOWN_POR  = 1'b1;

  // ALU operations; all but ASR_OP_NONE touch the flags
  typedef enum logic [2:0] {
    ASR_OP_NONE,
    ASR_OP_LOGIC,
    ASR_OP_ADD,
    ASR_OP_SUB,
    ASR_OP_RRF,
    ASR_OP_RLF
  } asr_op_t;

  // Reset and wake-up events
  typedef enum logic [2:0] {
    ASR_RST_NONE,
    ASR_RST_POR,
    ASR_RST_MASTER_CLEAR_PIN_RUN,
    ASR_RST_MASTER_CLEAR_PIN_WAKE,
    ASR_RST_WDT_RUN,
    ASR_RST_WDT_WAKE
  } asr_rst_t;

  // ALU request from the datapath
  typedef struct packed {
    asr_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
  } asr_alu_req_t;

  // Flag results of one ALU operation
  typedef struct packed {
    logic [7:0] result;
    logic       zero;
    logic       digit;
    logic       carry;
    logic       z_upd;
    logic       dc_upd;
    logic       c_upd;
  } asr_alu_flags_t;

  // Register file write from the datapath
  typedef struct packed {
    logic       en;
    logic [4:0] addr;
    logic [7:0] data;
  } asr_wr_t;

endpackage : asr_pkg

// ---- rtl/asr_flag_calc.sv ----
`timescale 1ns/1ps
module asr_flag_calc (
  // ALU request
  input  asr_pkg::asr_alu_req_t   req,
  input  wire logic               carry_in,
  // Result and flags
  output asr_pkg::asr_alu_flags_t flags
);

  logic [8:0] sum;
  logic [4:0] nib;

  // Flag computation; subtraction is f - w done as f + ~w + 1
  always_comb begin
    sum   = 9'h000;
    nib   = 5'h00;
    flags = '0;
    case (req.op)
      asr_pkg::ASR_OP_LOGIC: begin
        flags.result = req.a;
        flags.z_upd  = 1'b1;
      end
      asr_pkg::ASR_OP_ADD: begin
        sum          = {1'b0, req.a} + {1'b0, req.b};
        nib          = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]};
        flags.result = sum[7:0];
        flags.digit  = nib[4];
        flags.carry  = sum[8];
        flags.z_upd  = 1'b1;
        flags.dc_upd = 1'b1;
        flags.c_upd  = 1'b1;
      end
      asr_pkg::ASR_OP_SUB: begin
        sum          = {1'b0, req.a} + {1'b0, ~req.b} + 9'h001;
        nib          = {1'b0, req.a[3:0]} + {1'b0, ~req.b[3:0]} + 5'h01;
        flags.result = sum[7:0];
        flags.digit  = nib[4];                                  // Set means no borrow
        flags.carry  = sum[8];                                  // Inverted borrow
        flags.z_upd  = 1'b1;
        flags.dc_upd = 1'b1;
        flags.c_upd  = 1'b1;
      end
      asr_pkg::ASR_OP_RRF: begin
        flags.result = {carry_in, req.a[7:1]};
        flags.carry  = req.a[0];
        flags.c_upd  = 1'b1;
      end
      asr_pkg::ASR_OP_RLF: begin
        flags.result = {req.a[6:0], carry_in};
        flags.carry  = req.a[7];
        flags.c_upd  = 1'b1;
      end
      default: begin
        flags.result = req.a;
      end
    endcase
    flags.zero = (flags.result == 8'h00);
  end

endmodule // asr_flag_calc

// ---- rtl/asr_status.sv ----
`timescale 1ns/1ps
module asr_status (
  // Clock and control
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  // Reset and wake-up events from the reset logic
  input  asr_pkg::asr_rst_t          reset_event,
  input  wire logic                  master_clear_pin_n,
  input  wire logic                  watchdog_timeout,
  input  wire logic                  sleeping,
  // Instruction side
  input  asr_pkg::asr_alu_req_t      alu_req,
  input  asr_pkg::asr_wr_t           file_wr,
  input  wire logic                  watchdog_clear_instr,
  input  wire logic                  sleep_instr,
  // Outputs
  output logic [7:0]                 status,
  output logic [7:0]                 alu_result,
  output logic [1:0]                 program_page_select,
  output logic                       device_reset,
  output logic [2:0]                 last_reset_cause
);

  asr_pkg::asr_alu_flags_t flags;
  logic [2:0]  pin_sync;
  logic        pin_low;
  logic        next_pin_low;
  logic        sel_status;
  logic        ev_valid;
  asr_pkg::asr_rst_t ev;
  logic [7:0]  next_status;
  logic [7:0]  next_alu_result;
  logic        next_device_reset;
  logic [2:0]  next_last_reset_cause;

  // Flag arithmetic shared with the datapath
  asr_flag_calc u_calc (
    .req      (alu_req),
    .carry_in (status[asr_pkg::BIT_CARRY]),
    .flags    (flags)
  );

  // Pin synchroniser: first stage only feeds the second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_sync <= 3'h7;
    end else if (clk_en) begin
      pin_sync <= {pin_sync[1:0], master_clear_pin_n};
    end
  end

  // Pin counts as changed once stages two and three agree
  always_comb begin
    next_pin_low = pin_low;
    if (pin_sync[1] == pin_sync[2]) begin
      next_pin_low = ~pin_sync[2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_low <= 1'b0;
    end else if (clk_en) begin
      pin_low <= next_pin_low;
    end
  end

  // Merge explicit events with the pin and watchdog; sleep picks the wake variant
  always_comb begin
    ev = reset_event;
    if (ev == asr_pkg::ASR_RST_NONE) begin
      if (~pin_low & next_pin_low) begin
        ev = sleeping ? asr_pkg::ASR_RST_MASTER_CLEAR_PIN_WAKE : asr_pkg::ASR_RST_MASTER_CLEAR_PIN_RUN;
      end else if (watchdog_timeout) begin
        ev = sleeping ? asr_pkg::ASR_RST_WDT_WAKE : asr_pkg::ASR_RST_WDT_RUN;
      end
    end
    ev_valid   = (ev != asr_pkg::ASR_RST_NONE);
    sel_status = file_wr.en && (file_wr.addr == asr_pkg::STATUS_ADDR);
  end

  // Status next value: resets first, then instruction effects
  always_comb begin
    next_status           = status;
    next_alu_result       = flags.result;
    next_device_reset     = ev_valid;
    next_last_reset_cause = last_reset_cause;
    if (ev_valid) begin
      next_last_reset_cause = 3'(ev);
      next_status[7:5]      = asr_pkg::PAGE_RESET;
      case (ev)
        asr_pkg::ASR_RST_POR: begin
          next_status[asr_pkg::BIT_TIMEOUT]   = asr_pkg::TIMEOUT_POR;
          next_status[asr_pkg::BIT_POWERDOWN] = asr_pkg::POWERDOWN_POR;
        end
        asr_pkg::ASR_RST_MASTER_CLEAR_PIN_WAKE: begin
          next_status[asr_pkg::BIT_TIMEOUT]   = 1'b1;
          next_status[asr_pkg::BIT_POWERDOWN] = 1'b0;
        end
        asr_pkg::ASR_RST_WDT_RUN: begin
          next_status[asr_pkg::BIT_TIMEOUT]   = 1'b0;
          next_status[asr_pkg::BIT_POWERDOWN] = 1'b1;
        end
        asr_pkg::ASR_RST_WDT_WAKE: begin
          next_status[asr_pkg::BIT_TIMEOUT]   = 1'b0;
          next_status[asr_pkg::BIT_POWERDOWN] = 1'b0;
        end
        default: begin
          next_status = next_status;                                            // Clear pin in run keeps flags
        end
      endcase
      // Arithmetic flags are never reset, so they keep their value
    end else begin
      if (sel_status) begin
        // Only page bits and arithmetic flags take written data
        next_status[7:5] = file_wr.data[7:5];
        next_status[2:0] = file_wr.data[2:0];
      end
      // ALU flags win over the written data on the same bits
      if (flags.z_upd) begin
        next_status[asr_pkg::BIT_ZERO] = flags.zero;
      end
      if (flags.dc_upd) begin
        next_status[asr_pkg::BIT_DIGIT] = flags.digit;
      end
      if (flags.c_upd) begin
        next_status[asr_pkg::BIT_CARRY] = flags.carry;
      end
      if (watchdog_clear_instr) begin
        next_status[asr_pkg::BIT_TIMEOUT]   = 1'b1;
        next_status[asr_pkg::BIT_POWERDOWN] = 1'b1;
      end else if (sleep_instr) begin
        next_status[asr_pkg::BIT_TIMEOUT]   = 1'b1;
        next_status[asr_pkg::BIT_POWERDOWN] = 1'b0;
      end
    end
  end

  // One process owns all of status; rst acts as the power-on event
  always_ff @(posedge sys_clk) begin
    // Arithmetic flags have no reset term so they survive every reset
    if (clk_en && !rst) begin
      status[2:0] <= next_status[2:0];
      alu_result  <= next_alu_result;
    end
    if (rst) begin
      status[7:5]         <= asr_pkg::PAGE_RESET;
      status[4]           <= asr_pkg::TIMEOUT_POR;
      status[3]           <= asr_pkg::POWERDOWN_POR;
      program_page_select <= 2'h0;
      device_reset        <= 1'b1;
      last_reset_cause    <= 3'(asr_pkg::ASR_RST_POR);
    end else if (clk_en) begin
      status[7:3]         <= next_status[7:3];
      program_page_select <= next_status[asr_pkg::BIT_PAGE_HI:asr_pkg::BIT_PAGE_LO];
      device_reset        <= next_device_reset;
      last_reset_cause    <= next_last_reset_cause;
    end
  end

  // Checks
  wr_ignores_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && sel_status && !ev_valid && !watchdog_clear_instr && !sleep_instr
    |=> status[4:3] == $past(status[4:3]))
    else $error("cause flags changed by a write");
  alu_over_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !ev_valid && flags.c_upd |=> status[0] == $past(flags.carry))
    else $error("carry not taken from ALU");
  clear_status_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !ev_valid && sel_status && file_wr.data == 8'h00 && flags.z_upd && flags.zero
    |=> status[7:5] == 3'h0 && status[2] == 1'b1)
    else $error("clear of status wrong");
  page_out_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en |=> program_page_select == status[6:5])
    else $error("page select mismatch");
  zero_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !ev_valid && flags.z_upd |=> status[2] == (alu_result == 8'h00))
    else $error("zero flag wrong");
  wake_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && ev_valid |=> device_reset)
    else $error("no reset on wake");
  master_clear_pin_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && ev == asr_pkg::ASR_RST_MASTER_CLEAR_PIN_RUN |=> status[4:3] == $past(status[4:3]))
    else $error("clear pin changed cause flags");
  wdt_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && ev == asr_pkg::ASR_RST_WDT_RUN |=> status[4:3] == 2'b01 && status[7:5] == 3'h0)
    else $error("watchdog cause wrong");
  sleep_flags_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !ev_valid && sleep_instr && !watchdog_clear_instr |=> status[4:3] == 2'b10)
    else $error("sleep flags wrong");
  por_value_a: assert property (@(posedge sys_clk)
    rst |=> status[7:3] == 5'b00011)
    else $error("power-on value wrong");

  wdt_wake_c: cover property (@(posedge sys_clk) disable iff (rst) ev == asr_pkg::ASR_RST_WDT_WAKE);
  master_clear_pin_wake_c: cover property (@(posedge sys_clk) disable iff (rst) ev == asr_pkg::ASR_RST_MASTER_CLEAR_PIN_WAKE);
  sub_write_c: cover property (@(posedge sys_clk) disable iff (rst)
    sel_status && alu_req.op == asr_pkg::ASR_OP_SUB);

endmodule // asr_status

// ---- tb/asr_reset_src.sv ----
`timescale 1ns/1ps
module asr_reset_src (
  // Clock and requests from the bench
  input  wire logic sys_clk,
  input  wire logic pin_req,
  input  wire logic wdt_req,
  // Reset sources seen by the status block
  output logic      master_clear_pin_n,
  output logic      watchdog_timeout
);
  logic [3:0] low_cnt;

  initial begin
    low_cnt = 4'h0;
    master_clear_pin_n = 1'b1;
    watchdog_timeout = 1'b0;
  end

  // Pin idles high on its pull-up; held low long enough for the synchroniser
  always @(posedge sys_clk) begin
    if (pin_req)
      low_cnt <= 4'h8;
    else if (low_cnt != 4'h0)
      low_cnt <= low_cnt - 4'h1;
    master_clear_pin_n <= !(pin_req || low_cnt > 4'h1);
    watchdog_timeout <= wdt_req; // Expiry is a single pulse
  end
endmodule // asr_reset_src

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic                  sys_clk, rst, clk_en, sleeping, wclr, slp, pin_req, wdt_req, pin_n, wdt_to, dev_rst;
  asr_pkg::asr_rst_t     rst_ev;
  asr_pkg::asr_alu_req_t req;
  asr_pkg::asr_wr_t      wr;
  logic [7:0]            status, alu_res, m;
  logic [1:0]            page;
  logic [2:0]            cause;
  int                    fails, cmp_count;
  asr_pkg::asr_op_t      opl [5] = '{asr_pkg::ASR_OP_LOGIC, asr_pkg::ASR_OP_ADD, asr_pkg::ASR_OP_SUB,
                                     asr_pkg::ASR_OP_RRF, asr_pkg::ASR_OP_RLF};
  asr_pkg::asr_rst_t     evl [5] = '{asr_pkg::ASR_RST_WDT_RUN, asr_pkg::ASR_RST_MASTER_CLEAR_PIN_RUN, asr_pkg::ASR_RST_MASTER_CLEAR_PIN_WAKE,
                                     asr_pkg::ASR_RST_WDT_WAKE, asr_pkg::ASR_RST_POR};

  asr_status u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reset_event(rst_ev),
    .master_clear_pin_n(pin_n), .watchdog_timeout(wdt_to), .sleeping(sleeping), .alu_req(req), .file_wr(wr),
    .watchdog_clear_instr(wclr), .sleep_instr(slp), .status(status), .alu_result(alu_res),
    .program_page_select(page), .device_reset(dev_rst), .last_reset_cause(cause));
  asr_reset_src u_src (.sys_clk(sys_clk), .pin_req(pin_req), .wdt_req(wdt_req),
    .master_clear_pin_n(pin_n), .watchdog_timeout(wdt_to));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test;
    $display("fails %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Expected {result, status}: only the flags the operation owns move
  function automatic logic [15:0] calc(asr_pkg::asr_op_t o, logic [7:0] a, logic [7:0] b, logic [7:0] s, logic ci);
    logic [8:0] t;
    logic [7:0] r;
    r = a;
    case (o)
      asr_pkg::ASR_OP_ADD: begin
        t = {1'b0, a} + {1'b0, b};
        r = t[7:0];
        s[0] = t[8];
        s[1] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
      end
      asr_pkg::ASR_OP_SUB: begin
        t = {1'b0, a} - {1'b0, b};
        r = t[7:0];
        s[0] = !t[8];
        s[1] = a[3:0] >= b[3:0];
      end
      asr_pkg::ASR_OP_RRF: begin
        r = {ci, a[7:1]};
        s[0] = a[0];
      end
      asr_pkg::ASR_OP_RLF: begin
        r = {a[6:0], ci};
        s[0] = a[7];
      end
      default: ;
    endcase
    if (o == asr_pkg::ASR_OP_LOGIC || o == asr_pkg::ASR_OP_ADD || o == asr_pkg::ASR_OP_SUB)
      s[2] = (r == 8'h00);
    return {r, s};
  endfunction

  // One instruction: ALU operation, optional write to status, optional freeze
  task automatic op(asr_pkg::asr_op_t o, logic [7:0] a, logic [7:0] b, logic we, logic [7:0] d, logic en);
    logic [15:0] e;
    @(posedge sys_clk);
    req <= '{o, a, b};
    wr <= '{we, asr_pkg::STATUS_ADDR, d};
    clk_en <= en;
    @(posedge sys_clk);
    req <= '{asr_pkg::ASR_OP_NONE, 8'h00, 8'h00};
    wr.en <= 1'b0;
    clk_en <= 1'b1;
    #1;
    e = calc(o, a, b, we ? {d[7:5], m[4:3], d[2:0]} : m, m[0]);
    if (en)
      m = e[7:0];
    chk("status", m, status);
    chk("page", {6'h00, m[6:5]}, {6'h00, page});
    if (en && o != asr_pkg::ASR_OP_NONE)
      chk("alu_result", e[15:8], alu_res);
  endtask

  // Reset cause check; arithmetic flags survive, page bits clear
  task automatic ev_chk(logic [2:0] c, logic [1:0] tp);
    m = {3'b000, tp, m[2:0]};
    chk("status_rst", m, status);
    chk("dev_rst", 8'h01, {7'h00, dev_rst});
    chk("cause", {5'h00, c}, {5'h00, cause});
  endtask

  task automatic wait_rst;
    int k;
    k = 0;
    while (dev_rst !== 1'b1 && k < 12) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
  endtask

  initial begin
    logic [1:0] tpl [5] = '{2'b01, 2'b00, 2'b10, 2'b00, 2'b11};
    fails = 0;
    cmp_count = 0;
    {rst, clk_en, sleeping, wclr, slp, pin_req, wdt_req} = 7'h40;
    rst_ev = asr_pkg::ASR_RST_NONE;
    req = '{asr_pkg::ASR_OP_NONE, 8'h00, 8'h00};
    wr = '{1'b0, 5'h00, 8'h00};
    void'($urandom(32'h4dc71e96));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    m = {5'b00011, status[2:0]};
    chk("status_por", {m[7:3], 3'h0}, {status[7:3], 3'h0});
    chk("cause_por", 8'h01, {5'h00, cause});
    op(asr_pkg::ASR_OP_ADD, 8'h8f, 8'h71, 1'b0, 8'h00, 1'b1);
    op(asr_pkg::ASR_OP_NONE, 8'h00, 8'h00, 1'b1, 8'hff, 1'b1);
    op(asr_pkg::ASR_OP_LOGIC, 8'h00, 8'h00, 1'b1, 8'h00, 1'b1);
    op(asr_pkg::ASR_OP_SUB, 8'h10, 8'h01, 1'b0, 8'h00, 1'b1);
    for (int i = 0; i < 80; i++)
      op(opl[$urandom % 5], 8'($urandom), 8'($urandom), 1'($urandom), 8'($urandom), ($urandom % 8) != 0);
    for (int i = 0; i < 5; i++) begin
      op(asr_pkg::ASR_OP_NONE, 8'h00, 8'h00, 1'b1, {3'b111, m[4:0]}, 1'b1);
      @(posedge sys_clk);
      rst_ev <= evl[i];
      @(posedge sys_clk);
      rst_ev <= asr_pkg::ASR_RST_NONE;
      #1;
      ev_chk(evl[i], i == 1 ? m[4:3] : tpl[i]);
      @(posedge sys_clk);
      #1;
      chk("dev_rst_end", 8'h00, {7'h00, dev_rst});
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      {wclr, slp} <= i ? 2'b01 : 2'b10;
      @(posedge sys_clk);
      {wclr, slp} <= 2'b00;
      #1;
      m[4:3] = i ? 2'b10 : 2'b11;
      chk("status_instr", m, status);
    end
    @(posedge sys_clk);
    sleeping <= 1'b1;
    pin_req <= 1'b1;
    @(posedge sys_clk);
    pin_req <= 1'b0;
    wait_rst;
    ev_chk(asr_pkg::ASR_RST_MASTER_CLEAR_PIN_WAKE, 2'b10);
    @(posedge sys_clk);
    sleeping <= 1'b0;
    wdt_req <= 1'b1;
    @(posedge sys_clk);
    wdt_req <= 1'b0;
    wait_rst;
    ev_chk(asr_pkg::ASR_RST_WDT_RUN, 2'b01);
    stop_test;
  end

  // Run needs a few hundred cycles; cut off well beyond that
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("watchdog expired");
    stop_test;
  end
endmodule // tb_top
